// *** rtf_pkg.sv ***
package rtf_pkg;

    // Register indices on the serial port.
    localparam logic [3:0] ADDR_CTRL2 = 4'h1;
    localparam logic [3:0] ADDR_TIMER = 4'hE;
    localparam logic [3:0] ADDR_COUNT = 4'hF;

    // Interrupt control and flag register fields.
    localparam int BIT_MIN_SEL  = 7;
    localparam int BIT_SEC_SEL  = 6;
    localparam int BIT_MSF      = 5;
    localparam int BIT_PULSE    = 4;
    localparam int BIT_AF       = 3;
    localparam int BIT_TF       = 2;
    localparam int BIT_AIE      = 1;
    localparam int BIT_TIE      = 0;
    localparam logic [7:0] FLAG_MASK = 8'h2C;

    // Timer and clock output control fields.
    localparam int BIT_CD_EN    = 3;
    localparam logic [7:0] TIMER_MASK = 8'h7B;

    // Values after reset.
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] TIMER_RST = 8'h03;
    localparam logic [7:0] COUNT_RST = 8'h00;

    // Serial frame bit positions.
    localparam logic [4:0] CMD_LAST = 5'h07;
    localparam logic [4:0] WR_LAST  = 5'h0F;
    localparam logic [4:0] RD_FIRST = 5'h10;
    localparam logic [4:0] RD_LAST  = 5'h17;
    localparam logic [4:0] CNT_MAX  = 5'h1F;

    // Internal timing base.
    localparam int CLK_HZ       = 50_000_000;
    localparam int BASE_HZ      = 8192;
    localparam int TICK_DIV_DEF = CLK_HZ / BASE_HZ;

    // Pulse widths as fractions of a second, and their base tick counts.
    localparam int MS_PULSE_DIV   = 64;
    localparam int CORR_PULSE_DIV = 128;
    localparam int CD_FAST_N1_DIV = 8192;
    localparam int CD_FAST_DIV    = 4096;
    localparam int CD_MID_N1_DIV  = 128;
    localparam int CD_SLOW_DIV    = 64;
    localparam logic [7:0] MS_TICKS      = 8'(BASE_HZ / MS_PULSE_DIV);
    localparam logic [7:0] CORR_TICKS    = 8'(BASE_HZ / CORR_PULSE_DIV);
    localparam logic [7:0] CD_FAST1_TICK = 8'(BASE_HZ / CD_FAST_N1_DIV);
    localparam logic [7:0] CD_FAST_TICKS = 8'(BASE_HZ / CD_FAST_DIV);
    localparam logic [7:0] CD_MID1_TICKS = 8'(BASE_HZ / CD_MID_N1_DIV);
    localparam logic [7:0] CD_SLOW_TICKS = 8'(BASE_HZ / CD_SLOW_DIV);

    typedef enum logic [1:0] {
        SRC_4096HZ,
        SRC_64HZ,
        SRC_1HZ,
        SRC_MINUTE
    } rtf_src_type;

endpackage : rtf_pkg

// *** rtf_timer_irq.sv ***
`timescale 1ns/1ns
// Function
// - Countdown flag sets at each period end; only a host write clears it.
// - Countdown interrupt gated by enable; pulse per period or level following flag.
// - Pulse/level select applies to countdown and minute/second interrupts.
// - Reading the countdown register returns the live, running counter.
// - Offset correction pulses are a source of their own, apart from second and minute sources.
// - Selected minute/second events and alarm events set their flags, held until software writes.
// - Flag writes AND the written bit with the current flag.
// - Active low interrupt pin ORs minute/second, countdown, alarm, correction sources.
// - Each correction interrupt pulse lasts 1/128 second.
// - Alarm interrupt is never pulsed; it follows the alarm flag when enabled.
// - Minute/second pulse is counted in 8192 Hz base ticks and lasts 1/64 second.
// - Clearing the minute/second flag ends its pulse at once.
// - Level mode: both selects zero or flag cleared drops the interrupt.
// - Countdown pulse width depends on source clock and loaded value.
// - A loaded value of zero stops the countdown; no flag or interrupt.
// - Clearing the countdown flag ends its pulse at once.
// - Level mode: clearing the countdown interrupt enable drops the interrupt at once.
// - Both selects zero gives nothing; minute only per minute; second select per second.
// - At count one the flag sets, the value reloads and a period restarts.
// - Source select: 00 4.096 kHz, 01 64 Hz, 10 1 Hz, 11 per minute.
module rtf_timer_irq #(
    parameter int TICK_DIV = rtf_pkg::TICK_DIV_DEF
) (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic spi_clk,
    input  wire logic chip_sel_n,
    input  wire logic spi_mosi,
    output logic      spi_miso,
    output logic      spi_miso_oe,
    input  wire logic sec_event,
    input  wire logic min_event,
    input  wire logic alarm_event,
    input  wire logic corr_event,
    output logic      int_n
);
    import rtf_pkg::*;

    localparam int TW = $clog2(TICK_DIV);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // Serial side, clocked by the host clock; chip select clears the frame.
    logic [4:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] cmd_r;
    logic [7:0] wr_data_r;
    logic       wr_req_r;
    logic       rd_req_r;
    logic       miso_r;
    logic [7:0] rd_data_r;
    wire  [7:0] rx_byte = {shift_r[6:0], spi_mosi};
    wire  [2:0] rd_idx  = ~bit_cnt_r[2:0];
    wire        rd_slot = (bit_cnt_r >= RD_FIRST) && (bit_cnt_r <= RD_LAST);

    always_ff @(posedge spi_clk or posedge chip_sel_n) begin
        if (chip_sel_n) begin
            bit_cnt_r <= 5'h00;
        end else if (bit_cnt_r != CNT_MAX) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
        end
    end

    always_ff @(posedge spi_clk) begin
        shift_r <= rx_byte;
    end

    always_ff @(posedge spi_clk) begin
        if (bit_cnt_r == CMD_LAST) begin
            cmd_r <= rx_byte;
        end
        if (bit_cnt_r == WR_LAST) begin
            wr_data_r <= rx_byte;
        end
    end

    always_ff @(posedge spi_clk or posedge chip_sel_n) begin
        if (chip_sel_n) begin
            wr_req_r <= 1'b0;
            rd_req_r <= 1'b0;
        end else begin
            if (bit_cnt_r == CMD_LAST && shift_r[6]) begin
                rd_req_r <= 1'b1;
            end
            if (bit_cnt_r == WR_LAST && !cmd_r[7]) begin
                wr_req_r <= 1'b1;
            end
        end
    end

    // Read data is latched in the core domain before the first data slot.
    always_ff @(negedge spi_clk or posedge chip_sel_n) begin
        if (chip_sel_n) begin
            miso_r <= 1'b0;
        end else if (rd_slot) begin
            miso_r <= rd_data_r[rd_idx];
        end
    end

    assign spi_miso    = miso_r;
    assign spi_miso_oe = !chip_sel_n && cmd_r[7] && rd_slot;

    // Core side: request levels cross through two flip-flops.
    logic [2:0] wr_sync_r;
    logic [2:0] rd_sync_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_sync_r <= 3'h0;
            rd_sync_r <= 3'h0;
        end else begin
            wr_sync_r <= {wr_sync_r[1:0], wr_req_r};
            rd_sync_r <= {rd_sync_r[1:0], rd_req_r};
        end
    end

    wire wr_go  = wr_sync_r[1] && !wr_sync_r[2];
    wire rd_go  = rd_sync_r[1] && !rd_sync_r[2];
    wire wr_c2  = wr_go && (cmd_r[3:0] == ADDR_CTRL2);
    wire wr_tmr = wr_go && (cmd_r[3:0] == ADDR_TIMER);
    wire wr_cnt = wr_go && (cmd_r[3:0] == ADDR_COUNT);

    // Base tick at 8192 Hz and derived source ticks.
    logic [TW-1:0] tick_cnt_r;
    logic [12:0]   sub_cnt_r;
    wire           tick = (tick_cnt_r == TW'(TICK_DIV - 1));

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tick_cnt_r <= '0;
            sub_cnt_r  <= 13'h0000;
        end else begin
            tick_cnt_r <= tick ? '0 : tick_cnt_r + TW'(1);
            sub_cnt_r  <= tick ? sub_cnt_r + 13'h0001 : sub_cnt_r;
        end
    end

    logic [7:0] ctrl2_r;
    logic [7:0] timer_r;
    logic [7:0] load_r;
    logic [7:0] count_r;

    wire         min_sel   = ctrl2_r[BIT_MIN_SEL];
    wire         sec_sel   = ctrl2_r[BIT_SEC_SEL];
    wire         pulse_md  = ctrl2_r[BIT_PULSE];
    wire         cd_en     = timer_r[BIT_CD_EN];
    rtf_src_type src_sel;
    assign src_sel = rtf_src_type'(timer_r[1:0]);

    wire src_tick = (src_sel == SRC_4096HZ) ? (tick && sub_cnt_r[0]) :
                    (src_sel == SRC_64HZ)   ? (tick && (sub_cnt_r[6:0] == 7'h7F)) :
                    (src_sel == SRC_1HZ)    ? sec_event : min_event;

    wire cd_run  = cd_en && (load_r != 8'h00);
    wire cd_step = cd_run && src_tick;
    wire cd_done = cd_step && (count_r == 8'h01);
    wire ms_evt  = sec_sel ? sec_event : (min_sel && min_event);

    // Flags keep their value AND the written bit; a new event wins over a clear.
    wire [7:0] set_vec  = {2'b00, ms_evt, 1'b0, alarm_event, cd_done, 2'b00};
    wire [7:0] wr_mask  = wr_c2 ? wr_data_r : 8'hFF;
    wire [7:0] ctl_src  = wr_c2 ? wr_data_r : ctrl2_r;
    wire [7:0] ctrl2_nxt = (ctl_src & ~FLAG_MASK) |
                           (ctrl2_r & wr_mask & FLAG_MASK) | set_vec;

    wire [7:0] count_nxt = wr_cnt  ? wr_data_r :
                           cd_step ? ((count_r <= 8'h01) ? load_r : count_r - 8'h01) :
                           count_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl2_r <= CTRL2_RST;
            timer_r <= TIMER_RST;
            load_r  <= COUNT_RST;
            count_r <= COUNT_RST;
        end else begin
            ctrl2_r <= ctrl2_nxt;
            timer_r <= wr_tmr ? (wr_data_r & TIMER_MASK) : timer_r;
            load_r  <= wr_cnt ? wr_data_r : load_r;
            count_r <= count_nxt;
        end
    end

    wire [7:0] rd_mux = (cmd_r[3:0] == ADDR_CTRL2) ? ctrl2_r :
                        (cmd_r[3:0] == ADDR_TIMER) ? timer_r :
                        (cmd_r[3:0] == ADDR_COUNT) ? count_r : 8'h00;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_data_r <= 8'h00;
        end else if (rd_go) begin
            rd_data_r <= rd_mux;
        end
    end

    // Pulse width counters, in base ticks.
    wire [7:0] cd_width = (src_sel == SRC_4096HZ) ?
                              ((load_r == 8'h01) ? CD_FAST1_TICK : CD_FAST_TICKS) :
                          (src_sel == SRC_64HZ) ?
                              ((load_r == 8'h01) ? CD_MID1_TICKS : CD_SLOW_TICKS) :
                          CD_SLOW_TICKS;
    logic [7:0] ms_pcnt_r;
    logic [7:0] cd_pcnt_r;
    logic [7:0] corr_pcnt_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ms_pcnt_r   <= 8'h00;
            cd_pcnt_r   <= 8'h00;
            corr_pcnt_r <= 8'h00;
        end else begin
            ms_pcnt_r   <= ms_evt ? MS_TICKS :
                           (tick && ms_pcnt_r != 8'h00) ? ms_pcnt_r - 8'h01 : ms_pcnt_r;
            cd_pcnt_r   <= cd_done ? cd_width :
                           (tick && cd_pcnt_r != 8'h00) ? cd_pcnt_r - 8'h01 : cd_pcnt_r;
            corr_pcnt_r <= corr_event ? CORR_TICKS :
                           (tick && corr_pcnt_r != 8'h00) ? corr_pcnt_r - 8'h01 :
                           corr_pcnt_r;
        end
    end

    wire minute_second_flag    = ctrl2_r[BIT_MSF];
    wire tf     = ctrl2_r[BIT_TF];
    wire ms_irq = pulse_md ? ((ms_pcnt_r != 8'h00) && minute_second_flag) :
                             (minute_second_flag && (min_sel || sec_sel));
    wire cd_irq = ctrl2_r[BIT_TIE] &&
                  (pulse_md ? ((cd_pcnt_r != 8'h00) && tf) : tf);
    wire al_irq = ctrl2_r[BIT_AIE] && ctrl2_r[BIT_AF];
    wire cr_irq = corr_pcnt_r != 8'h00;
    logic int_n_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            int_n_r <= 1'b1;
        end else begin
            int_n_r <= !(ms_irq || cd_irq || al_irq || cr_irq);
        end
    end

    assign int_n = int_n_r;

    tf_only_sw_a: assert property ($fell(tf) |-> $past(wr_c2 && !wr_data_r[BIT_TF]))
        else $error("Countdown flag cleared without a host write.");
    flag_and_a: assert property (wr_c2 && !wr_data_r[BIT_MSF] && !ms_evt |=> !minute_second_flag)
        else $error("Minute/second flag survived a zero write.");
    flag_set_a: assert property (alarm_event || (ctrl2_r[BIT_AF] && !wr_c2)
                                 |=> ctrl2_r[BIT_AF])
        else $error("Alarm flag not set and held after event.");
    alarm_level_a: assert property (al_irq |=> !int_n)
        else $error("Enabled alarm flag did not pull the interrupt low.");
    zero_stop_a: assert property (load_r == 8'h00 && !wr_cnt
                                  |=> $stable(count_r) && !$rose(tf))
        else $error("Countdown ran with a zero load value.");
    reload_a: assert property (cd_done && !wr_cnt |=> count_r == $past(load_r))
        else $error("Countdown did not reload at the end of a period.");
    cd_width_a: assert property (cd_done && src_sel == SRC_4096HZ && load_r == 8'h01
                                 |=> cd_pcnt_r == CD_FAST1_TICK)
        else $error("Wrong countdown pulse width for the fastest source.");
    corr_width_a: assert property (corr_event |=> corr_pcnt_r == 8'h40)
        else $error("Correction pulse not loaded with 1/128 second.");
    level_off_a: assert property (!pulse_md && !ctrl2_r[BIT_TIE] && !min_sel && !sec_sel
                                  && !al_irq && !cr_irq |=> int_n)
        else $error("Interrupt held low with all level sources off.");
    ms_sel_off_a: assert property (!min_sel && !sec_sel |=> !$rose(minute_second_flag))
        else $error("Minute/second flag set with both selects clear.");

    // Interrupt clears, enables and pulse loads.
    ms_clear_a: assert property (wr_c2 && !wr_data_r[BIT_MSF] && !ms_evt |=> !ms_irq)
        else $error("Minute/second interrupt outlived its flag clear.");
    cd_clear_a: assert property (wr_c2 && !wr_data_r[BIT_TF] && !cd_done |=> !cd_irq)
        else $error("Countdown interrupt outlived its flag clear.");
    tie_off_a: assert property (wr_c2 && !wr_data_r[BIT_TIE] |=> !cd_irq)
        else $error("Countdown interrupt held with its enable cleared.");
    sel_off_a: assert property (wr_c2 && !wr_data_r[BIT_PULSE] && !wr_data_r[BIT_MIN_SEL]
                                && !wr_data_r[BIT_SEC_SEL] |=> !ms_irq)
        else $error("Level minute/second interrupt held with both selects clear.");
    ms_width_a: assert property (ms_evt |=> ms_pcnt_r == MS_TICKS)
        else $error("Minute/second pulse not loaded with 1/64 second.");
    ms_pulse_on_a: assert property (pulse_md && ms_evt && !wr_c2 |=> ms_irq)
        else $error("Minute/second event gave no pulse in pulse mode.");
    cd_level_a: assert property (!pulse_md && ctrl2_r[BIT_TIE] && tf |=> !int_n)
        else $error("Level countdown interrupt did not pull the pin low.");
    corr_pin_a: assert property (cr_irq |=> !int_n)
        else $error("Correction pulse did not reach the interrupt pin.");
    tf_set_a: assert property (cd_done |=> tf)
        else $error("Countdown flag not set at the end of a period.");
    al_off_a: assert property (wr_c2 && !wr_data_r[BIT_AF] && !alarm_event |=> !al_irq)
        else $error("Alarm interrupt outlived its flag clear.");
    live_read_a: assert property (rd_go && cmd_r[3:0] == ADDR_COUNT
                                  |=> rd_data_r == $past(count_r))
        else $error("Countdown read did not return the live counter.");
    sec_step_a: assert property (cd_run && src_sel == SRC_1HZ && sec_event && !wr_cnt
                                 && count_r > 8'h01
                                 |=> count_r == $past(count_r) - 8'h01)
        else $error("Countdown did not step on the second source.");

endmodule : rtf_timer_irq

// *** rtf_host.sv ***
`timescale 1ns/1ns
module rtf_host (
    output logic       spi_clk,
    output logic       chip_sel_n,
    output logic       spi_mosi,
    input  wire logic  spi_miso,
    output logic [7:0] rd_data,
    output logic       rd_done
);
    initial begin
        spi_clk    = 1'b0;
        chip_sel_n = 1'b1;
        spi_mosi   = 1'b1;
        rd_data    = 8'h00;
        rd_done    = 1'b0;
    end

    // The serial clock runs at 160 ns only within frames; counters are read on slow sources.
    task automatic xfer(input logic rd, input logic [3:0] adr, input logic [7:0] wd);
        logic [23:0] sh;
        sh = {rd, 3'h0, adr, wd, 8'h00};
        chip_sel_n = 1'b0;
        for (int i = 0; i < (rd ? 24 : 16); i++) begin
            spi_mosi = sh[23-i];
            #80 spi_clk = 1'b1;
            if (i > 15) rd_data = {rd_data[6:0], spi_miso};
            #80 spi_clk = 1'b0;
        end
        #160 chip_sel_n = 1'b1;
        spi_mosi = ~spi_mosi;
        rd_done = rd;
        #160 rd_done = 1'b0;
    endtask : xfer
endmodule : rtf_host

// *** test_rtf_timer_flags_interrupt.sv ***
`timescale 1ns/1ns
module test_rtf_timer_flags_interrupt;
    import rtf_pkg::*;
    localparam int TD = 4;
    localparam logic [3:0] SEC = 4'h8;
    localparam logic [3:0] MIN = 4'h4;
    localparam logic [3:0] ALM = 4'h2;
    localparam logic [3:0] COR = 4'h1;
    logic       core_clk;
    logic       reset;
    logic       spi_clk;
    logic       chip_sel_n;
    logic       spi_mosi;
    logic       spi_miso;
    logic       int_n;
    logic       rd_done;
    logic [7:0] rd_data;
    logic [7:0] rnd;
    logic [3:0] ev;
    logic [7:0] exp_q[$];
    int         error_cnt;
    int         checked;
    logic       miso_oe;
    int         oe_cnt;

    rtf_timer_irq #(.TICK_DIV(TD)) DUT (
        .core_clk(core_clk), .reset(reset), .spi_clk(spi_clk),
        .chip_sel_n(chip_sel_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(miso_oe), .sec_event(ev[3]), .min_event(ev[2]),
        .alarm_event(ev[1]), .corr_event(ev[0]), .int_n(int_n));
    rtf_host host (
        .spi_clk(spi_clk), .chip_sel_n(chip_sel_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .rd_data(rd_data), .rd_done(rd_done));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.xfer(1'b1, a, 8'h00);
    endtask : rd

    task automatic pulse(input logic [3:0] m);
        @(posedge core_clk);
        ev <= m;
        @(posedge core_clk);
        ev <= 4'h0;
        repeat (8) @(posedge core_clk);
    endtask : pulse

    task automatic pin(input logic e);
        @(negedge core_clk);
        chk({7'h00, int_n}, {7'h00, e}, "int pin");
    endtask : pin

    task automatic pwidth(input logic [3:0] m, input int lo, input int hi);
        int n;
        n = 0;
        for (int i = 0; i < 3000 && int_n !== 1'b1; i++) @(posedge core_clk);
        if (m != 4'h0) pulse(m);
        for (int i = 0; i < 3000 && int_n !== 1'b0; i++) @(posedge core_clk);
        while (int_n === 1'b0 && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        chk(8'(n >= lo && n <= hi), 8'h01, "pulse width");
    endtask : pwidth

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial begin
        #1_000_000;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end

    always @(posedge rd_done) begin
        if (exp_q.size() == 0) begin
            error_cnt++;
            $display("[ERR] %0t read with no expected value", $time);
        end else begin
            chk(rd_data, exp_q.pop_front(), "read");
        end
        chk(8'(oe_cnt), 8'h08, "miso enable slots");
        oe_cnt = 0;
    end

    always @(posedge spi_clk) begin
        if (miso_oe === 1'b1) oe_cnt++;
    end

    initial begin
        reset = 1'b1;
        ev = 4'h0;
        error_cnt = 0;
        checked = 0;
        oe_cnt = 0;
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        rnd = 8'($urandom(32'h82e9));
        rd(ADDR_CTRL2, CTRL2_RST);
        rd(ADDR_TIMER, TIMER_RST);
        rd(ADDR_COUNT, COUNT_RST);
        rd(4'h5, 8'h00);
        wr(ADDR_TIMER, 8'hFF);
        rd(ADDR_TIMER, TIMER_MASK);
        wr(ADDR_TIMER, TIMER_RST);
        $display("test registers done");
        wr(ADDR_CTRL2, 8'h40);
        pulse(SEC | ALM);
        rd(ADDR_CTRL2, 8'h68);
        wr(ADDR_CTRL2, 8'h48);
        rd(ADDR_CTRL2, 8'h48);
        rnd = 8'($urandom) & 8'h08;
        wr(ADDR_CTRL2, 8'h40 | rnd);
        rd(ADDR_CTRL2, 8'h40 | rnd);
        wr(ADDR_CTRL2, 8'h00);
        pulse(SEC | MIN);
        rd(ADDR_CTRL2, 8'h00);
        wr(ADDR_CTRL2, 8'h80);
        pulse(SEC);
        rd(ADDR_CTRL2, 8'h80);
        pulse(MIN);
        rd(ADDR_CTRL2, 8'hA0);
        $display("test flags done");
        wr(ADDR_CTRL2, 8'h02);
        pulse(ALM);
        pin(1'b0);
        repeat (700) @(posedge core_clk);
        pin(1'b0);
        wr(ADDR_CTRL2, 8'h02);
        pin(1'b1);
        wr(ADDR_CTRL2, 8'h50);
        pwidth(SEC, 500, 518);
        wr(ADDR_CTRL2, 8'h50);
        pulse(SEC);
        pin(1'b0);
        wr(ADDR_CTRL2, 8'h50);
        pin(1'b1);
        wr(ADDR_CTRL2, 8'h40);
        pulse(SEC);
        pin(1'b0);
        wr(ADDR_CTRL2, 8'h20);
        pin(1'b1);
        rd(ADDR_CTRL2, 8'h20);
        wr(ADDR_CTRL2, 8'h02);
        pulse(ALM);
        pwidth(COR, 3000, 3000);
        wr(ADDR_CTRL2, 8'h00);
        pwidth(COR, 244, 262);
        $display("test interrupt pin done");
        wr(ADDR_CTRL2, 8'h01);
        wr(ADDR_TIMER, 8'h0A);
        wr(ADDR_COUNT, 8'h05);
        repeat (2) pulse(SEC);
        rd(ADDR_COUNT, 8'h03);
        rd(ADDR_COUNT, 8'h03);
        pin(1'b1);
        repeat (3) pulse(SEC);
        rd(ADDR_CTRL2, 8'h05);
        pin(1'b0);
        wr(ADDR_CTRL2, 8'h04);
        pin(1'b1);
        rd(ADDR_CTRL2, 8'h04);
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_CTRL2, 8'h01);
        repeat (3) pulse(SEC);
        rd(ADDR_CTRL2, 8'h01);
        $display("test countdown done");
        wr(ADDR_CTRL2, 8'h11);
        wr(ADDR_TIMER, 8'h09);
        wr(ADDR_COUNT, 8'h01);
        pwidth(4'h0, 250, 262);
        wr(ADDR_COUNT, 8'h02);
        pwidth(4'h0, 506, 518);
        for (int i = 0; i < 3000 && int_n !== 1'b0; i++) @(posedge core_clk);
        pin(1'b0);
        wr(ADDR_CTRL2, 8'h11);
        pin(1'b1);
        wr(ADDR_TIMER, 8'h08);
        wr(ADDR_COUNT, 8'h01);
        pwidth(4'h0, 3, 5);
        wr(ADDR_COUNT, 8'h02);
        pwidth(4'h0, 7, 9);
        wr(ADDR_TIMER, TIMER_RST);
        wr(ADDR_CTRL2, 8'h00);
        $display("test countdown pulse done");
        end_of_test();
    end
endmodule : test_rtf_timer_flags_interrupt
